// file: flash_access_defs.svh
`ifndef FLASH_ACCESS_DEFS_SVH
`define FLASH_ACCESS_DEFS_SVH
// Register indices; the byte address on the bus is four times the index.
`define IDX_PROG_CTRL   8'h29
`define IDX_TARGET_ADDR 8'h2c
`define IDX_TARGET_DATA 8'h2d
`define IDX_GUARD       8'h2e
`define IDX_COMMAND     8'h2f
`define IDX_OPTION      8'h30
`define IDX_STATUS      8'h31
// Reset values.
`define RST_PROG_CTRL   8'h00
// Guard key sequence that arms one command.
`define GUARD_KEY1      8'h56
`define GUARD_KEY2      8'hae
// Link byte that asks for in-circuit communication mode.
`define LINK_ENTRY_KEY  8'ha5
// Command field positions.
`define CMD_OP_LSB      0
`define CMD_SECT_LSB    2
// Status field positions.
`define ST_BUSY         0
`define ST_ERR          1
`define ST_PROTECT      2
`define ST_ICC          3
`define ST_TOOL         4
`define ST_ARMED        5
// Sector zero holds the vectors at the top 4 Kbytes.
`define SECT0_BASE      16'hf000
`define SECT1_BASE      16'he000
`endif

// file: flash_access_pkg.sv
package flash_access_pkg;
   // Flash operation requested of the array.
   typedef enum logic [1:0] {
      OP_NONE,
      OP_PROG_BYTE,
      OP_SECT_ERASE,
      OP_MASS_ERASE
   } flash_op_t;
   // Programming mode in force.
   typedef enum logic [1:0] {
      MODE_LOCKED,
      MODE_APP,
      MODE_ICP,
      MODE_TOOL
   } prog_mode_t;
   // Sequencer states.
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_OP,
      SEQ_UNPROTECT
   } seq_state_t;
endpackage : flash_access_pkg

// file: flash_sector_access_control.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "flash_access_defs.svh"
// Overview of operation
// RL1: Erase one sector, other sectors untouched.
// RL2: Program bytes; erase whole array or sector.
// RL3: Two 4K top sectors; sector zero F000h-FFFFh.
// RL4: Sector count follows array size.
// RL5: Protection blocks extraction and flash writes.
// RL6: Removing protection first erases whole array.
// RL7: One option bit controls readout protection.
// RL8: Application mode never touches sector zero.
// RL9: Tool and in-circuit modes reach everything.
// RL10: Key guard prevents accidental program or erase.
// RL11: Tool must enter communication mode first; tool presence alone gives MODE_TOOL full access here.
// RL12: Link uses reset, clock, data, voltage select.
// RL13: Attached tool reserves clock and data pins.
// RL14: Tool drives device reset during session.
// RL15: Application asserts no reset during session.
// RL16: Smaller parts enter with external clock.
// RL17: Control byte at 29h, read/write, resets 00h.
module flash_sector_access_control #(
   parameter int FLASH_KB      = 32,
   parameter bit PROTECT_INIT  = 1'b0
) (
   // Core clock and reset.
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   // AXI4-Lite register slave.
   input  wire logic [7:0]                  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [7:0]                  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Request port to the flash array.
   output flash_access_pkg::flash_op_t      flash_op,
   output logic                             flash_op_valid,
   output logic [15:0]                      flash_addr,
   output logic [1:0]                       flash_sector,
   output logic [7:0]                       flash_wdata,
   input  wire logic                        flash_done,
   // Program memory readout gate.
   output logic                             readout_blocked,
   // In-circuit link pins.
   input  wire logic                        incircuit_serial_clock,
   input  wire logic                        incircuit_serial_data_in,
   output logic                             incircuit_serial_data_out,
   output logic                             incircuit_serial_data_oe,
   input  wire logic                        prog_voltage_select,
   input  wire logic                        tool_present,
   // Mode and pin ownership indications.
   output logic                             incircuit_comm_mode,
   output logic                             link_pins_reserved
);
   import flash_access_pkg::*;

   // Number of user sectors for a given array size.
   function automatic logic [1:0] sector_count(input int kb);
      if (kb <= 4) begin
         return 2'd1;
      end else if (kb <= 8) begin
         return 2'd2;
      end
      return 2'd3;
   endfunction : sector_count

   // Sector that holds an address.
   function automatic logic [1:0] sector_of(input logic [15:0] a);
      if (a >= `SECT0_BASE) begin // RL3
         return 2'd0;
      end else if (a >= `SECT1_BASE) begin
         return 2'd1;
      end
      return 2'd2;
   endfunction : sector_of

   localparam logic [1:0]  NUM_SECT   = sector_count(FLASH_KB); // RL4
   localparam logic [16:0] FLASH_BASE = 17'h10000 - 17'(FLASH_KB * 1024);

   // Link clock domain.
   logic [1:0] lrst_sync_ff;      // Core reset carried into the link domain.
   logic [1:0] lsel_sync_ff;      // Voltage select seen on the link clock.
   logic [1:0] lack_sync_ff;      // Core acknowledge toggle, synchronised.
   logic [7:0] lshift_ff;         // Serial data shift register.
   logic [2:0] lbits_ff;          // Bits gathered in the current byte.
   logic [7:0] lbyte_ff;          // Byte held for the core.
   logic       lbyte_tgl_ff;      // Toggles once per byte handed over.
   logic       lreply_ff;         // Drives the data pin low for one cycle.
   wire        lbusy = lbyte_tgl_ff != lack_sync_ff[1];

   // Reset and select synchronisers; the link clock may stop between frames.
   always_ff @(posedge incircuit_serial_clock) begin
      lrst_sync_ff <= {lrst_sync_ff[0], sys_rst};
      lsel_sync_ff <= {lsel_sync_ff[0], prog_voltage_select};
   end

   // Gather bytes while selected; hold a byte until the core takes it.
   always_ff @(posedge incircuit_serial_clock) begin
      if (lrst_sync_ff[1] || !lsel_sync_ff[1]) begin
         lbits_ff     <= 3'd0;
         lreply_ff    <= 1'b0;
         lbyte_tgl_ff <= lack_sync_ff[1];
         lshift_ff    <= 8'h00;
         lbyte_ff     <= 8'h00;
      end else begin
         lreply_ff <= 1'b0;
         if (!lbusy) begin
            lshift_ff <= {lshift_ff[6:0], incircuit_serial_data_in};
            lbits_ff  <= lbits_ff + 3'd1;
            if (lbits_ff == 3'd7) begin
               // The held byte is stable until the core echoes the toggle.
               lbyte_ff     <= {lshift_ff[6:0], incircuit_serial_data_in};
               lbyte_tgl_ff <= ~lbyte_tgl_ff;
               lreply_ff    <= 1'b1;
            end
         end
      end
   end

   // Open-drain style reply on the two-way data pin.
   assign incircuit_serial_data_out = 1'b0; // RL12
   assign incircuit_serial_data_oe  = lreply_ff; // RL12

   // Core clock domain.
   logic [2:0] tgl_sync_ff;       // Byte toggle: two syncs plus edge history.
   logic       ack_tgl_ff;        // Echo of the byte toggle to the link.
   logic [1:0] sel_sync_ff;       // Voltage select pin synchroniser.
   logic [1:0] tool_sync_ff;      // Tool presence pin synchroniser.
   logic       icc_mode_ff;       // In-circuit communication mode.
   logic       reserved_ff;       // Link pins withheld from the application.

   // The acknowledge is read only by the link synchroniser.
   always_ff @(posedge incircuit_serial_clock) begin
      lack_sync_ff <= {lack_sync_ff[0], ack_tgl_ff};
   end

   // Pin synchronisers in the core domain.
   always_ff @(posedge clk) begin
      tgl_sync_ff  <= {tgl_sync_ff[1:0], lbyte_tgl_ff};
      sel_sync_ff  <= {sel_sync_ff[0], prog_voltage_select};
      tool_sync_ff <= {tool_sync_ff[0], tool_present};
   end

   wire byte_evt = tgl_sync_ff[2] != tgl_sync_ff[1];

   // Take each byte; the entry key with select high enters the mode.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_tgl_ff  <= 1'b0;
         icc_mode_ff <= 1'b0;
      end else begin
         if (byte_evt) begin
            ack_tgl_ff <= tgl_sync_ff[1];
         end
         if (!sel_sync_ff[1]) begin
            icc_mode_ff <= 1'b0;
         end else if (byte_evt && lbyte_ff == `LINK_ENTRY_KEY) begin
            icc_mode_ff <= 1'b1; // RL11
         end
      end
   end

   // Pins stay reserved while a tool is attached, session or not.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reserved_ff <= 1'b0;
      end else begin
         reserved_ff <= tool_sync_ff[1] | icc_mode_ff; // RL13
      end
   end

   assign incircuit_comm_mode = icc_mode_ff;
   assign link_pins_reserved  = reserved_ff;

   // Registers.
   logic [7:0]  prog_ctrl_ff;     // Tool software control byte.
   logic [15:0] tgt_addr_ff;      // Target flash address.
   logic [7:0]  tgt_data_ff;      // Byte to program.
   logic        key1_ff;          // First guard key seen.
   logic        armed_ff;         // Guard armed for one command.
   logic        app_prog_ff;      // Software enables application programming.
   logic        protect_ff;       // Readout protection option bit.
   logic        err_ff;           // Sticky refusal flag, write one to clear.
   seq_state_t  seq_ff;           // Operation sequencer.
   flash_op_t   op_ff;            // Operation being issued.
   logic [1:0]  op_sect_ff;       // Sector of the operation.
   prog_mode_t  mode;             // Mode in force.

   // In-circuit mode outranks the tool, then the application.
   always_comb begin
      if (tool_sync_ff[1] && !icc_mode_ff) begin
         mode = MODE_TOOL;
      end else if (icc_mode_ff) begin
         mode = MODE_ICP;
      end else if (app_prog_ff) begin
         mode = MODE_APP;
      end else begin
         mode = MODE_LOCKED;
      end
   end

   // AXI write side; address and data in either order.
   logic       aw_have_ff;
   logic       w_have_ff;
   logic [5:0] aw_idx_ff;
   logic [7:0] w_byte_ff;
   logic       w_lane_ff;
   logic       bvalid_ff;
   logic [1:0] bresp_ff;
   assign s_axi_awready = !aw_have_ff && !bvalid_ff;
   assign s_axi_wready  = !w_have_ff && !bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

   wire       wr_go   = aw_have_ff && w_have_ff && !bvalid_ff;
   wire [7:0] wr_idx  = {2'b00, aw_idx_ff};
   wire       wr_en   = wr_go && w_lane_ff;
   wire       idx_ok  = wr_idx == `IDX_PROG_CTRL || wr_idx == `IDX_TARGET_ADDR ||
                        wr_idx == `IDX_TARGET_DATA || wr_idx == `IDX_GUARD ||
                        wr_idx == `IDX_COMMAND || wr_idx == `IDX_OPTION ||
                        wr_idx == `IDX_STATUS;

   // Hold each half until both arrive.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         aw_idx_ff  <= 6'd0;
         w_byte_ff  <= 8'h00;
         w_lane_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            aw_idx_ff  <= s_axi_awaddr[7:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            w_byte_ff <= s_axi_wdata[7:0];
            w_lane_ff <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= idx_ok ? 2'b00 : 2'b10;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Command decode and the refusal checks.
   wire       cmd_wr   = wr_en && wr_idx == `IDX_COMMAND;
   wire [1:0] cmd_op   = w_byte_ff[`CMD_OP_LSB +: 2];
   wire [1:0] cmd_sect = (cmd_op == 2'd1) ? sector_of(tgt_addr_ff) : w_byte_ff[`CMD_SECT_LSB +: 2];
   wire       in_array = {1'b0, tgt_addr_ff} >= FLASH_BASE;
   wire       full_mode = mode == MODE_ICP || mode == MODE_TOOL; // RL9
   logic      cmd_ok;

   always_comb begin
      cmd_ok = armed_ff && seq_ff == SEQ_IDLE && !protect_ff; // RL5 RL10
      case (cmd_op)
         2'd1: cmd_ok = cmd_ok && in_array && (full_mode ||
                        (mode == MODE_APP && cmd_sect != 2'd0));
         2'd2: cmd_ok = cmd_ok && cmd_sect < NUM_SECT && (full_mode ||
                        (mode == MODE_APP && cmd_sect != 2'd0)); // RL1 RL8
         2'd3: cmd_ok = cmd_ok && full_mode; // RL2
         default: cmd_ok = 1'b0;
      endcase
   end

   wire opt_wr   = wr_en && wr_idx == `IDX_OPTION;
   wire opt_ok   = armed_ff && full_mode && seq_ff == SEQ_IDLE;
   wire unprot   = opt_wr && opt_ok && protect_ff && !w_byte_ff[0];
   wire refused  = (cmd_wr && !cmd_ok) || (opt_wr && !opt_ok);

   // Storage registers and the application enable.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prog_ctrl_ff <= `RST_PROG_CTRL; // RL17
         tgt_addr_ff  <= 16'h0000;
         tgt_data_ff  <= 8'h00;
         app_prog_ff  <= 1'b0;
      end else if (wr_en) begin
         case (wr_idx)
            `IDX_PROG_CTRL:   prog_ctrl_ff <= w_byte_ff; // RL17
            `IDX_TARGET_ADDR: tgt_addr_ff  <= {tgt_addr_ff[7:0], w_byte_ff};
            `IDX_TARGET_DATA: tgt_data_ff  <= w_byte_ff;
            `IDX_STATUS:      app_prog_ff  <= w_byte_ff[7];
            default: ;
         endcase
      end
   end

   // Guard: two keys in order arm exactly one command or option write.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         key1_ff  <= 1'b0;
         armed_ff <= 1'b0;
      end else if (wr_en && wr_idx == `IDX_GUARD) begin
         key1_ff  <= w_byte_ff == `GUARD_KEY1; // RL10
         armed_ff <= key1_ff && w_byte_ff == `GUARD_KEY2; // RL10
      end else if (cmd_wr || opt_wr) begin
         key1_ff  <= 1'b0;
         armed_ff <= 1'b0;
      end
   end

   // Refusals are sticky; a new refusal wins over a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         err_ff <= 1'b0;
      end else if (refused) begin
         err_ff <= 1'b1;
      end else if (wr_en && wr_idx == `IDX_STATUS && w_byte_ff[`ST_ERR]) begin
         err_ff <= 1'b0;
      end
   end

   // Operation sequencer; protection drops only after the mass erase ends.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         seq_ff     <= SEQ_IDLE;
         op_ff      <= OP_NONE;
         op_sect_ff <= 2'd0;
         protect_ff <= PROTECT_INIT; // RL7
      end else begin
         case (seq_ff)
            SEQ_IDLE: begin
               if (unprot) begin
                  seq_ff <= SEQ_UNPROTECT;
                  op_ff  <= OP_MASS_ERASE; // RL6
               end else if (opt_wr && opt_ok) begin
                  protect_ff <= w_byte_ff[0]; // RL7
               end else if (cmd_wr && cmd_ok) begin
                  seq_ff     <= SEQ_OP;
                  op_ff      <= flash_op_t'(cmd_op);
                  op_sect_ff <= cmd_sect;
               end
            end
            SEQ_OP: begin
               if (flash_done) begin
                  seq_ff <= SEQ_IDLE;
                  op_ff  <= OP_NONE;
               end
            end
            SEQ_UNPROTECT: begin
               if (flash_done) begin
                  seq_ff     <= SEQ_IDLE;
                  op_ff      <= OP_NONE;
                  protect_ff <= 1'b0; // RL6
               end
            end
            default: seq_ff <= SEQ_IDLE;
         endcase
      end
   end

   assign flash_op        = op_ff;
   assign flash_op_valid  = seq_ff != SEQ_IDLE;
   assign flash_addr      = tgt_addr_ff;
   assign flash_sector    = op_sect_ff;
   assign flash_wdata     = tgt_data_ff;
   // Extraction over the link or in a tool is cut while protected.
   assign readout_blocked = protect_ff && mode != MODE_APP && mode != MODE_LOCKED; // RL5

   // AXI read side; answer a cycle after the address.
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic [7:0]  rd_val;
   logic        rd_ok;
   wire  [7:0]  rd_idx = {2'b00, s_axi_araddr[7:2]};
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   // Read multiplexer; unmapped indices answer with a slave error.
   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 8'h00;
      case (rd_idx)
         `IDX_PROG_CTRL:   rd_val = prog_ctrl_ff;
         `IDX_TARGET_ADDR: rd_val = tgt_addr_ff[7:0];
         `IDX_TARGET_DATA: rd_val = tgt_data_ff;
         `IDX_GUARD:       rd_val = 8'h00;
         `IDX_COMMAND:     rd_val = {4'h0, op_sect_ff, op_ff};
         `IDX_OPTION:      rd_val = {7'h00, protect_ff};
         `IDX_STATUS:      rd_val = {app_prog_ff, NUM_SECT[0], armed_ff, reserved_ff,
                                     icc_mode_ff, protect_ff, err_ff, flash_op_valid};
         default:          rd_ok  = 1'b0;
      endcase
   end

   // Read response register.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= {24'h00_0000, rd_val};
         rresp_ff  <= rd_ok ? 2'b00 : 2'b10;
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Checks.
   property p_app_spares_sect0;
      @(posedge clk) disable iff (sys_rst)
      $rose(flash_op_valid) && $past(mode) == MODE_APP |->
         op_sect_ff != 2'd0 && op_ff != OP_MASS_ERASE;
   endproperty
   a_app_spares_sect0: assert property (p_app_spares_sect0) else $error("sector zero hit"); // RL8

   property p_protect_no_write;
      @(posedge clk) disable iff (sys_rst)
      $rose(flash_op_valid) && $past(protect_ff) |-> seq_ff == SEQ_UNPROTECT;
   endproperty
   a_protect_no_write: assert property (p_protect_no_write) else $error("protected write"); // RL5

   property p_unprotect_after_erase;
      @(posedge clk) disable iff (sys_rst)
      $fell(protect_ff) |-> $past(seq_ff) == SEQ_UNPROTECT && $past(flash_done);
   endproperty
   a_unprotect_after_erase: assert property (p_unprotect_after_erase) // RL6
      else $error("early unprotect");

   property p_unprotect_erases;
      @(posedge clk) disable iff (sys_rst)
      unprot |=> flash_op_valid && op_ff == OP_MASS_ERASE && protect_ff;
   endproperty
   a_unprotect_erases: assert property (p_unprotect_erases) else $error("no mass erase"); // RL6

   property p_guard_armed;
      @(posedge clk) disable iff (sys_rst)
      $rose(flash_op_valid) |-> $past(armed_ff) && !armed_ff;
   endproperty
   a_guard_armed: assert property (p_guard_armed) else $error("operation without guard"); // RL10

   property p_sector_exists;
      @(posedge clk) disable iff (sys_rst)
      flash_op_valid && op_ff == OP_SECT_ERASE |-> op_sect_ff < NUM_SECT;
   endproperty
   a_sector_exists: assert property (p_sector_exists) else $error("missing sector"); // RL1 RL4

   property p_sect0_top;
      @(posedge clk) disable iff (sys_rst)
      flash_op_valid && op_ff == OP_PROG_BYTE && op_sect_ff == 2'd0 |-> flash_addr[15:12] == 4'hf;
   endproperty
   a_sect0_top: assert property (p_sect0_top) else $error("sector zero outside top"); // RL3

   property p_pins_reserved;
      @(posedge clk) disable iff (sys_rst)
      tool_sync_ff[1] |=> link_pins_reserved;
   endproperty
   a_pins_reserved: assert property (p_pins_reserved) else $error("pins not reserved"); // RL13

   property p_ctrl_reset;
      @(posedge clk) sys_rst |=> prog_ctrl_ff == 8'h00;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control byte reset wrong"); // RL17
endmodule : flash_sector_access_control

// file: flash_sector_access_control_tb_top.sv
`timescale 1ns/1ps
`include "flash_access_defs.svh"
// Counts and compares.
`define CHK(n, a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
   $display("ERROR %s exp %0h got %0h", n, e, a); end end
module flash_sector_access_control_tb_top;
   import flash_access_pkg::*;
   // Bench-driven inputs.
   logic        clk = 1'b0, sys_rst = 1'b1, flash_done = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, flash_wdata;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   // Design outputs.
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, flash_sector;
   logic [15:0] flash_addr;
   flash_op_t   flash_op;
   logic        flash_op_valid, readout_blocked, incircuit_comm_mode, link_pins_reserved;
   // Link wires; the ack pull-down wins.
   logic        incircuit_serial_clock, tool_data, prog_voltage_select, tool_present;
   logic        incircuit_serial_data_out, incircuit_serial_data_oe, incircuit_serial_data_in;
   logic [2:0]  wait_cnt = 3'h0;
   int          fails = 0, checks_done = 0, acks = 0;
   assign incircuit_serial_data_in = incircuit_serial_data_oe ? incircuit_serial_data_out
                                                                : tool_data;
   flash_sector_access_control
      i_flash_sector_access_control (
      .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .flash_op, .flash_op_valid, .flash_addr, .flash_sector,
      .flash_wdata, .flash_done, .readout_blocked, .incircuit_serial_clock,
      .incircuit_serial_data_in, .incircuit_serial_data_out, .incircuit_serial_data_oe,
      .prog_voltage_select, .tool_present, .incircuit_comm_mode, .link_pins_reserved);
   prog_tool_model i_prog_tool_model (.incircuit_serial_clock, .tool_data,
      .prog_voltage_select, .tool_present);
   // Counts link acks.
   always @(posedge incircuit_serial_data_oe) acks++;
   // 10 MHz core clock.
   initial forever #50 clk = ~clk;
   // The array answers after four cycles.
   always @(posedge clk) begin
      wait_cnt <= (flash_op_valid === 1'b1 && !flash_done) ? wait_cnt + 3'h1 : 3'h0;
      flash_done <= !sys_rst && flash_op_valid === 1'b1 && !flash_done && wait_cnt == 3'h3;
   end
   // One write; the response lands in rrsp.
   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      @(posedge clk);
      s_axi_awaddr <= {ix[5:0], 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rrsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   // One read into rdat and rrsp.
   task automatic rd(input logic [7:0] ix);
      @(posedge clk);
      s_axi_araddr <= {ix[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // Arms the guard once.
   task automatic arm();
      wr(`IDX_GUARD, `GUARD_KEY1);
      wr(`IDX_GUARD, `GUARD_KEY2);
   endtask : arm
   // Guarded command; checks the array request.
   task automatic cmd(input flash_op_t o, input logic [1:0] s, input logic ok,
                      input logic [15:0] a = 16'h0, input logic [7:0] dd = 8'h0);
      if (o == OP_PROG_BYTE) begin
         wr(`IDX_TARGET_ADDR, a[15:8]);
         wr(`IDX_TARGET_ADDR, a[7:0]);
         wr(`IDX_TARGET_DATA, dd);
      end
      arm();
      wr(`IDX_COMMAND, {4'h0, s, o});
      `CHK("op_valid", flash_op_valid, ok)
      if (ok) begin
         `CHK("op", flash_op, o)
         `CHK("sector", flash_sector, s)
         if (o == OP_PROG_BYTE) `CHK("addr_data", {flash_addr, flash_wdata}, {a, dd})
      end
      repeat (8) @(posedge clk);
   endtask : cmd
   // Prints the verdict and ends the run.
   task automatic wrap_up();
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // Ends a hang after 4000 cycles.
   initial begin
      #400000;
      fails++;
      wrap_up();
   end
   // The link resets only once the core has reset.
   initial begin
      repeat (2) @(posedge clk);
      i_prog_tool_model.pulse(4);
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rd(`IDX_PROG_CTRL);
      `CHK("prog_ctrl_reset", rdat, 32'h0)
      wr(`IDX_PROG_CTRL, 8'h5a);
      rd(`IDX_PROG_CTRL);
      `CHK("prog_ctrl_rw", rdat, 32'h5a)
      rd(8'h3f);
      `CHK("unmapped", rrsp, 2'b10)
      wr(8'h3f, 8'h00);
      `CHK("unmapped_wr", rrsp, 2'b10)
      wr(`IDX_STATUS, 8'h80);
      cmd(OP_PROG_BYTE, 2'd1, 1'b1, 16'he012, 8'h3c);
      wr(`IDX_COMMAND, {4'h0, 2'd2, OP_SECT_ERASE});
      `CHK("unguarded", flash_op_valid, 1'b0)
      cmd(OP_SECT_ERASE, 2'd0, 1'b0);
      rd(`IDX_STATUS);
      `CHK("err", rdat[`ST_ERR], 1'b1)
      `CHK("sectors", rdat[6], 1'b1)
      cmd(OP_SECT_ERASE, 2'd2, 1'b1);
      cmd(OP_MASS_ERASE, 2'd0, 1'b0);
      i_prog_tool_model.pins(1'b1, 1'b0);
      repeat (4) @(posedge clk);
      `CHK("pins_reserved", link_pins_reserved, 1'b1)
      // No reset until the session closes.
      i_prog_tool_model.pins(1'b1, 1'b1);
      i_prog_tool_model.send_byte(`LINK_ENTRY_KEY);
      for (int k = 0; k < 20 && !incircuit_comm_mode; k++) @(posedge clk);
      `CHK("comm_mode", incircuit_comm_mode, 1'b1)
      `CHK("link_ack", acks, 1)
      cmd(OP_PROG_BYTE, 2'd0, 1'b1, 16'hf000, 8'ha7);
      cmd(OP_MASS_ERASE, 2'd0, 1'b1);
      arm();
      wr(`IDX_OPTION, 8'h01);
      repeat (8) @(posedge clk);
      `CHK("blocked", readout_blocked, 1'b1)
      cmd(OP_SECT_ERASE, 2'd1, 1'b0);
      arm();
      wr(`IDX_OPTION, 8'h00);
      `CHK("unprotect_erase", flash_op, OP_MASS_ERASE)
      `CHK("held_blocked", readout_blocked, 1'b1)
      repeat (8) @(posedge clk);
      `CHK("unblocked", readout_blocked, 1'b0)
      i_prog_tool_model.pins(1'b1, 1'b0);
      repeat (6) @(posedge clk);
      `CHK("comm_mode_off", incircuit_comm_mode, 1'b0)
      `CHK("pins_kept", link_pins_reserved, 1'b1)
      wrap_up();
   end
endmodule : flash_sector_access_control_tb_top

// file: prog_tool_model.sv
`timescale 1ns/1ps
// Programming tool at the far end of the link.
module prog_tool_model (
   // Link pins.
   output logic incircuit_serial_clock,
   output logic tool_data,
   output logic prog_voltage_select,
   output logic tool_present
);
   // Clock idles low; the tool starts detached.
   initial begin
      incircuit_serial_clock = 1'b0;
      tool_data = 1'b1;
      prog_voltage_select = 1'b0;
      tool_present = 1'b0;
   end
   // 12 ns link cycles; data moves while low.
   task automatic pulse(input int n);
      repeat (n) begin
         #6 incircuit_serial_clock = 1'b1;
         #6 incircuit_serial_clock = 1'b0;
      end
   endtask : pulse
   // Attachment and select levels.
   task automatic pins(input logic att, input logic sel);
      tool_present = att;
      prog_voltage_select = sel;
   endtask : pins
   // One byte MSB first, ack room and a quiet gap.
   task automatic send_byte(input logic [7:0] b);
      pulse(2);
      for (int i = 7; i >= 0; i--) begin
         tool_data = b[i];
         pulse(1);
      end
      tool_data = ~b[0];
      pulse(3);
      #600;
   endtask : send_byte
endmodule : prog_tool_model
